// ---- rtl/pws_pkg.sv ----
// pws_pkg: register map, field positions, reset values and carriers for the warning/status block
// assumes: command codes arrive from a transaction layer as 8-bit codes
package pws_pkg;

  // ****************************************
  // command codes
  // ****************************************
  localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] CMD_CAPABILITY = 8'h19;
  localparam logic [7:0] CMD_OVERCURRENT_LIMIT = 8'h4A;
  localparam logic [7:0] CMD_RAIL_OV_LIMIT = 8'h57;
  localparam logic [7:0] CMD_RAIL_UV_LIMIT = 8'h58;
  localparam logic [7:0] CMD_OVERPOWER_LIMIT = 8'h6B;
  localparam logic [7:0] CMD_STATUS_BYTE = 8'h78;
  localparam logic [7:0] CMD_STATUS_WORD = 8'h79;
  localparam logic [7:0] CMD_CURRENT_FLAGS = 8'h7B;
  localparam logic [7:0] CMD_INPUT_FLAGS = 8'h7C;
  localparam logic [7:0] CMD_VENDOR_FLAGS = 8'h80;
  localparam logic [7:0] CMD_AUX_OV_LIMIT = 8'hDE;
  localparam logic [7:0] CMD_AUX_UV_LIMIT = 8'hDF;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [15:0] RST_OVERCURRENT_LIMIT = 16'h07FF;
  localparam logic [15:0] RST_RAIL_OV_LIMIT = 16'h0FFF;
  localparam logic [15:0] RST_RAIL_UV_LIMIT = 16'h0000;
  localparam logic [15:0] RST_OVERPOWER_LIMIT = 16'h7FFF;
  localparam logic [15:0] RST_AUX_OV_LIMIT = 16'h0FFF;
  localparam logic [15:0] RST_AUX_UV_LIMIT = 16'h0000;
  localparam logic [7:0] CAPABILITY_VALUE = 8'hB0;
  localparam logic [15:0] LIMIT12_MASK = 16'h0FFF;

  // ****************************************
  // field positions
  // ****************************************
  localparam int ALERT_CAPABLE_BIT = 4;
  localparam int COMM_FAULT_BIT = 1;
  localparam int OTHER_PENDING_BIT = 0;
  localparam int CURRENT_SUMMARY_BIT = 14;
  localparam int INPUT_SUMMARY_BIT = 13;
  localparam int VENDOR_SUMMARY_BIT = 12;
  localparam int OVERCURRENT_BIT = 5;
  localparam int RAIL_OV_BIT = 6;
  localparam int RAIL_UV_BIT = 5;
  localparam int OVERPOWER_BIT = 0;
  localparam int AUX_OV_BIT = 6;
  localparam int AUX_UV_BIT = 5;
  localparam int READ_LATENCY = 1;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic [11:0] rail;
    logic [11:0] aux;
    logic [15:0] current;
    logic [15:0] power;
  } pws_meas_t;

  typedef struct packed {
    logic overcurrent;
    logic rail_ov;
    logic rail_uv;
    logic overpower;
    logic aux_ov;
    logic aux_uv;
  } pws_trip_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] cmd;
    logic [15:0] wdata;
  } pws_req_t;

endpackage

// ---- rtl/pws_meas_cdc.sv ----
// pws_meas_cdc: carries one measurement set from the link clock into the core clock
// assumes: link side presents a one-cycle valid with stable data; sets spaced by at least 6 core cycles
`timescale 1ns/1ps
module pws_meas_cdc
  import pws_pkg::*;
(
  input wire logic link_clock,
  input wire logic clock,
  input wire logic nrst,
  input wire logic meas_valid,
  input wire pws_pkg::pws_meas_t meas_in,
  output logic meas_strobe,
  output pws_pkg::pws_meas_t meas_out
);
  import pws_pkg::*;

  // ****************************************
  // link side: hold words, flip toggle
  // ****************************************
  pws_meas_t hold_reg;
  logic tog_reg;
  always_ff @(posedge link_clock or negedge nrst)
  begin
    if (!nrst)
    begin
      hold_reg <= '0;
      tog_reg <= 1'b0;
    end
    else if (meas_valid)
    begin
      hold_reg <= meas_in;
      tog_reg <= ~tog_reg;
    end
  end

  // ****************************************
  // core side: two flops, then edge detect
  // ****************************************
  logic sync1_reg;
  logic sync2_reg;
  logic sync3_reg;
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      sync3_reg <= 1'b0;
    end
    else
    begin
      sync1_reg <= tog_reg;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      meas_strobe <= 1'b0;
      meas_out <= '0;
    end
    else
    begin
      meas_strobe <= sync2_reg ^ sync3_reg;
      if (sync2_reg ^ sync3_reg)
        meas_out <= hold_reg;
    end
  end
endmodule

// ---- rtl/pws_compare.sv ----
// pws_compare: combinational limit comparisons for one measurement set
// assumes: current and power are two's complement; voltages unsigned 12-bit
`timescale 1ns/1ps
module pws_compare
  import pws_pkg::*;
(
  input wire pws_pkg::pws_meas_t meas,
  input wire logic [11:0] oc_limit,
  input wire logic [15:0] op_limit,
  input wire logic [11:0] rail_ov_limit,
  input wire logic [11:0] rail_uv_limit,
  input wire logic [11:0] aux_ov_limit,
  input wire logic [11:0] aux_uv_limit,
  output pws_pkg::pws_trip_t trip
);
  import pws_pkg::*;

  logic signed [15:0] oc_lim_s;
  logic signed [15:0] cur_s;
  logic signed [15:0] op_lim_s;
  logic signed [15:0] pow_s;

  // 12-bit limit sign-extended to the current width
  assign oc_lim_s = {{4{oc_limit[11]}}, oc_limit};
  assign cur_s = meas.current;
  assign op_lim_s = op_limit;
  assign pow_s = meas.power;

  assign trip.overcurrent = oc_lim_s[15] ? (cur_s < oc_lim_s) : (cur_s > oc_lim_s);
  assign trip.overpower = op_lim_s[15] ? (pow_s < op_lim_s) : (pow_s > op_lim_s);
  assign trip.rail_ov = meas.rail > rail_ov_limit;
  assign trip.rail_uv = meas.rail < rail_uv_limit;
  assign trip.aux_ov = meas.aux > aux_ov_limit;
  assign trip.aux_uv = meas.aux < aux_uv_limit;
endmodule

// ---- rtl/pws_status.sv ----
// pws_status: warning limits, latched status flags and the status read-back of a power monitor
// assumes: command strobes from a transaction layer on clock; measurements arrive on link_clock
// What this block does
// - capability bit 4 one, low nibble zero
// - overcurrent limit 12 bits, reset 0x7FF
// - current trips in direction of limit sign
// - overpower limit 16 bit signed, reset 0x7FFF
// - overvoltage limit 12 bits, reset 0xFFF
// - undervoltage limit 12 bits, reset 0x000
// - latch comm fault on bus errors
// - status bit 0 live OR others
// - status byte is status word low byte
// - word bit 14 ORs current flags
// - word bit 13 ORs input flags
// - word bit 12 ORs vendor flags
// - current flags bit 5 latches overcurrent
// - input bit 6 latches rail overvoltage
// - input bit 5 latches rail undervoltage
// - input bit 0 latches overpower
// - vendor bit 6 latches aux overvoltage
// - vendor bit 5 latches aux undervoltage
// - clear command clears all latched flags
`timescale 1ns/1ps
module pws_status
  import pws_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic link_clock,
  input wire logic meas_valid,
  input wire pws_pkg::pws_meas_t meas_in,
  input wire pws_pkg::pws_req_t req,
  input wire logic bus_error,
  output logic [15:0] rdata,
  output logic rvalid,
  output logic unsupported,
  output logic [7:0] current_warning_flags,
  output logic [7:0] input_warning_flags,
  output logic [7:0] vendor_warning_flags
);
  import pws_pkg::*;

  // ****************************************
  // measurement crossing and comparison
  // ****************************************
  logic meas_strobe;
  pws_meas_t meas;
  pws_trip_t trip;

  pws_meas_cdc u_cdc (
    .link_clock(link_clock),
    .clock(clock),
    .nrst(nrst),
    .meas_valid(meas_valid),
    .meas_in(meas_in),
    .meas_strobe(meas_strobe),
    .meas_out(meas)
  );

  logic [11:0] overcurrent_limit_reg;
  logic [11:0] rail_overvoltage_limit_reg;
  logic [11:0] rail_undervoltage_limit_reg;
  logic [15:0] overpower_limit_reg;
  logic [11:0] aux_overvoltage_limit_reg;
  logic [11:0] aux_undervoltage_limit_reg;

  pws_compare u_cmp (
    .meas(meas),
    .oc_limit(overcurrent_limit_reg),
    .op_limit(overpower_limit_reg),
    .rail_ov_limit(rail_overvoltage_limit_reg),
    .rail_uv_limit(rail_undervoltage_limit_reg),
    .aux_ov_limit(aux_overvoltage_limit_reg),
    .aux_uv_limit(aux_undervoltage_limit_reg),
    .trip(trip)
  );

  // ****************************************
  // command decode
  // ****************************************
  logic known_cmd;
  logic clear_cmd;
  always_comb
  begin
    unique case (req.cmd)
      CMD_CLEAR_FAULTS, CMD_CAPABILITY, CMD_OVERCURRENT_LIMIT, CMD_RAIL_OV_LIMIT,
      CMD_RAIL_UV_LIMIT, CMD_OVERPOWER_LIMIT, CMD_STATUS_BYTE, CMD_STATUS_WORD,
      CMD_CURRENT_FLAGS, CMD_INPUT_FLAGS, CMD_VENDOR_FLAGS, CMD_AUX_OV_LIMIT,
      CMD_AUX_UV_LIMIT: known_cmd = 1'b1;
      default: known_cmd = 1'b0;
    endcase
  end
  assign clear_cmd = req.wr && (req.cmd == CMD_CLEAR_FAULTS);

  // ****************************************
  // limit registers
  // ****************************************
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      overcurrent_limit_reg <= RST_OVERCURRENT_LIMIT[11:0];
      rail_overvoltage_limit_reg <= RST_RAIL_OV_LIMIT[11:0];
      rail_undervoltage_limit_reg <= RST_RAIL_UV_LIMIT[11:0];
      overpower_limit_reg <= RST_OVERPOWER_LIMIT;
      aux_overvoltage_limit_reg <= RST_AUX_OV_LIMIT[11:0];
      aux_undervoltage_limit_reg <= RST_AUX_UV_LIMIT[11:0];
    end
    else if (req.wr)
    begin
      unique case (req.cmd)
        CMD_OVERCURRENT_LIMIT: overcurrent_limit_reg <= req.wdata[11:0];
        CMD_RAIL_OV_LIMIT: rail_overvoltage_limit_reg <= req.wdata[11:0];
        CMD_RAIL_UV_LIMIT: rail_undervoltage_limit_reg <= req.wdata[11:0];
        CMD_OVERPOWER_LIMIT: overpower_limit_reg <= req.wdata;
        CMD_AUX_OV_LIMIT: aux_overvoltage_limit_reg <= req.wdata[11:0];
        CMD_AUX_UV_LIMIT: aux_undervoltage_limit_reg <= req.wdata[11:0];
        default: ;
      endcase
    end
  end

  // ****************************************
  // latched flags
  // ****************************************
  logic comm_fault_flag_reg;
  logic comm_err;
  logic [7:0] current_next;
  logic [7:0] input_next;
  logic [7:0] vendor_next;
  logic [7:0] cur_set;
  logic [7:0] in_set;
  logic [7:0] ven_set;

  assign comm_err = bus_error || ((req.wr || req.rd) && !known_cmd);

  always_comb
  begin
    cur_set = '0;
    in_set = '0;
    ven_set = '0;
    if (meas_strobe)
    begin
      cur_set[OVERCURRENT_BIT] = trip.overcurrent;
      in_set[RAIL_OV_BIT] = trip.rail_ov;
      in_set[RAIL_UV_BIT] = trip.rail_uv;
      in_set[OVERPOWER_BIT] = trip.overpower;
      ven_set[AUX_OV_BIT] = trip.aux_ov;
      ven_set[AUX_UV_BIT] = trip.aux_uv;
    end
    // hold until clear; set beats clear
    current_next = (clear_cmd ? 8'h00 : current_warning_flags) | cur_set;
    input_next = (clear_cmd ? 8'h00 : input_warning_flags) | in_set;
    vendor_next = (clear_cmd ? 8'h00 : vendor_warning_flags) | ven_set;
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      current_warning_flags <= 8'h00;
      input_warning_flags <= 8'h00;
      vendor_warning_flags <= 8'h00;
    end
    else
    begin
      current_warning_flags <= current_next;
      input_warning_flags <= input_next;
      vendor_warning_flags <= vendor_next;
    end
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      comm_fault_flag_reg <= 1'b0;
    else if (comm_err)
      comm_fault_flag_reg <= 1'b1;
    else if (clear_cmd)
      comm_fault_flag_reg <= 1'b0;
  end

  // ****************************************
  // summary status
  // ****************************************
  logic current_flags_summary;
  logic input_flags_summary;
  logic vendor_flags_summary;
  logic other_flags_pending;
  logic [7:0] summary_status_byte;
  logic [15:0] summary_status_word;
  logic [7:0] interface_capability;

  assign current_flags_summary = |current_warning_flags;
  assign input_flags_summary = |input_warning_flags;
  assign vendor_flags_summary = |vendor_warning_flags;
  assign other_flags_pending = current_flags_summary | input_flags_summary | vendor_flags_summary;

  always_comb
  begin
    summary_status_byte = 8'h00;
    summary_status_byte[COMM_FAULT_BIT] = comm_fault_flag_reg;
    summary_status_byte[OTHER_PENDING_BIT] = other_flags_pending;
    summary_status_word = 16'h0000;
    summary_status_word[7:0] = summary_status_byte;
    summary_status_word[CURRENT_SUMMARY_BIT] = current_flags_summary;
    summary_status_word[INPUT_SUMMARY_BIT] = input_flags_summary;
    summary_status_word[VENDOR_SUMMARY_BIT] = vendor_flags_summary;
  end

  assign interface_capability = CAPABILITY_VALUE;

  // ****************************************
  // read-back
  // ****************************************
  logic [15:0] rd_next;
  always_comb
  begin
    unique case (req.cmd)
      CMD_CAPABILITY: rd_next = {8'h00, interface_capability};
      CMD_OVERCURRENT_LIMIT: rd_next = {4'h0, overcurrent_limit_reg};
      CMD_RAIL_OV_LIMIT: rd_next = {4'h0, rail_overvoltage_limit_reg};
      CMD_RAIL_UV_LIMIT: rd_next = {4'h0, rail_undervoltage_limit_reg};
      CMD_OVERPOWER_LIMIT: rd_next = overpower_limit_reg;
      CMD_AUX_OV_LIMIT: rd_next = {4'h0, aux_overvoltage_limit_reg};
      CMD_AUX_UV_LIMIT: rd_next = {4'h0, aux_undervoltage_limit_reg};
      CMD_STATUS_BYTE: rd_next = {8'h00, summary_status_byte};
      CMD_STATUS_WORD: rd_next = summary_status_word;
      CMD_CURRENT_FLAGS: rd_next = {8'h00, current_warning_flags};
      CMD_INPUT_FLAGS: rd_next = {8'h00, input_warning_flags};
      CMD_VENDOR_FLAGS: rd_next = {8'h00, vendor_warning_flags};
      default: rd_next = 16'h0000;
    endcase
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      rdata <= 16'h0000;
      rvalid <= 1'b0;
      unsupported <= 1'b0;
    end
    else
    begin
      rvalid <= req.rd;
      unsupported <= (req.wr || req.rd) && !known_cmd;
      if (req.rd)
        rdata <= rd_next;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  AST_CAPABILITY: assert property (@(posedge clock) disable iff (!nrst)
    req.rd && req.cmd == CMD_CAPABILITY |=> rdata[ALERT_CAPABLE_BIT] && rdata[3:0] == 4'h0)
    else $error("capability read wrong");

  AST_OC_RESERVED: assert property (@(posedge clock) disable iff (!nrst)
    req.rd && req.cmd == CMD_OVERCURRENT_LIMIT |=> rdata[15:12] == 4'h0)
    else $error("overcurrent limit upper bits nonzero");

  AST_CLEAR: assert property (@(posedge clock) disable iff (!nrst)
    clear_cmd && !meas_strobe && !comm_err |=> current_warning_flags == 8'h00
      && input_warning_flags == 8'h00 && vendor_warning_flags == 8'h00 && !comm_fault_flag_reg)
    else $error("clear did not clear flags");

  AST_HOLD: assert property (@(posedge clock) disable iff (!nrst)
    !clear_cmd |=> (input_warning_flags & $past(input_warning_flags)) == $past(input_warning_flags))
    else $error("input flag dropped without clear");

  AST_COMM: assert property (@(posedge clock) disable iff (!nrst)
    comm_err |=> comm_fault_flag_reg)
    else $error("comm fault not latched");

  AST_PENDING: assert property (@(posedge clock) disable iff (!nrst)
    req.rd && req.cmd == CMD_STATUS_BYTE |=> rdata[OTHER_PENDING_BIT] == ($past(current_warning_flags) != 8'h00
      || $past(input_warning_flags) != 8'h00 || $past(vendor_warning_flags) != 8'h00))
    else $error("pending bit mismatch");

  sequence s_oc_meas;
    meas_strobe && trip.overcurrent;
  endsequence
  AST_OC_LATCH: assert property (@(posedge clock) disable iff (!nrst)
    s_oc_meas |=> current_warning_flags[OVERCURRENT_BIT] ##1 (current_warning_flags[OVERCURRENT_BIT] || $past(clear_cmd)))
    else $error("overcurrent flag not latched");

  AST_WORD_LOW: assert property (@(posedge clock) disable iff (!nrst)
    req.rd && req.cmd == CMD_STATUS_WORD |=> rdata[7:0] == $past(summary_status_byte)
      && rdata[15] == 1'b0 && rdata[11:8] == 4'h0)
    else $error("status word low byte mismatch");

  AST_NO_SPURIOUS: assert property (@(posedge clock) disable iff (!nrst)
    !meas_strobe && clear_cmd |=> input_warning_flags == 8'h00)
    else $error("flag set without measurement");

  AST_RAIL_OV: assert property (@(posedge clock) disable iff (!nrst)
    meas_strobe && trip.rail_ov |=> input_warning_flags[RAIL_OV_BIT])
    else $error("rail overvoltage flag not latched");

  AST_RAIL_UV: assert property (@(posedge clock) disable iff (!nrst)
    meas_strobe && trip.rail_uv |=> input_warning_flags[RAIL_UV_BIT])
    else $error("rail undervoltage flag not latched");

  AST_OVERPOWER: assert property (@(posedge clock) disable iff (!nrst)
    meas_strobe && trip.overpower |=> input_warning_flags[OVERPOWER_BIT])
    else $error("overpower flag not latched");

  AST_AUX_OV: assert property (@(posedge clock) disable iff (!nrst)
    meas_strobe && trip.aux_ov |=> vendor_warning_flags[AUX_OV_BIT])
    else $error("aux overvoltage flag not latched");

  AST_AUX_UV: assert property (@(posedge clock) disable iff (!nrst)
    meas_strobe && trip.aux_uv |=> vendor_warning_flags[AUX_UV_BIT])
    else $error("aux undervoltage flag not latched");

  AST_RESERVED: assert property (@(posedge clock) disable iff (!nrst)
    current_warning_flags[7:6] == 2'h0 && current_warning_flags[4:0] == 5'h00 && !input_warning_flags[7]
      && input_warning_flags[4:1] == 4'h0 && !vendor_warning_flags[7] && vendor_warning_flags[4:0] == 5'h00)
    else $error("reserved flag bit set");

  AST_CUR_SUMMARY: assert property (@(posedge clock) disable iff (!nrst)
    req.rd && req.cmd == CMD_STATUS_WORD |=> rdata[CURRENT_SUMMARY_BIT] == ($past(current_warning_flags) != 8'h00))
    else $error("current summary bit mismatch");

  AST_IN_SUMMARY: assert property (@(posedge clock) disable iff (!nrst)
    req.rd && req.cmd == CMD_STATUS_WORD |=> rdata[INPUT_SUMMARY_BIT] == ($past(input_warning_flags) != 8'h00))
    else $error("input summary bit mismatch");

  AST_VEN_SUMMARY: assert property (@(posedge clock) disable iff (!nrst)
    req.rd && req.cmd == CMD_STATUS_WORD |=> rdata[VENDOR_SUMMARY_BIT] == ($past(vendor_warning_flags) != 8'h00))
    else $error("vendor summary bit mismatch");

endmodule

// ---- dv/pws_host_model.sv ----
// pws_host_model: bus host issuing command writes and reads
// assumes: one-cycle wr/rd strobes taken at the next clock edge
`timescale 1ns/1ps
module pws_host_model
  import pws_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  output pws_pkg::pws_req_t req,
  input wire logic [15:0] rdata,
  input wire logic rvalid,
  input wire logic unsupported
);
  import pws_pkg::*;

  initial req = '0;

  // ****************************************
  // bus cycles
  // ****************************************
  task automatic write_reg(input logic [7:0] c, input logic [15:0] w);
    @(posedge clock);
    req <= '{1'b1, 1'b0, c, w};
    @(posedge clock);
    req <= '{1'b0, 1'b0, ~c, ~w};
  endtask

  task automatic read_reg(input logic [7:0] c, output logic [15:0] d, output logic v, output logic u);
    @(posedge clock);
    req <= '{1'b0, 1'b1, c, 16'h0000};
    @(posedge clock);
    req <= '{1'b0, 1'b0, ~c, 16'hFFFF};
    @(posedge clock);
    d = rdata;
    v = rvalid;
    u = unsupported;
  endtask

  task automatic clear_faults();
    write_reg(CMD_CLEAR_FAULTS, 16'h0000);
  endtask
endmodule

// ---- dv/test_pws_status.sv ----
// test_pws_status: self-checking bench for the warning/status block
// assumes: host model on the command port, bench drives the link side
`timescale 1ns/1ps
module test_pws_status;
  import pws_pkg::*;

  logic clock = 1'b0;
  logic link_clock = 1'b0;
  logic nrst = 1'b0;
  logic meas_valid = 1'b0;
  pws_meas_t meas_in = '0;
  pws_req_t req;
  logic bus_error = 1'b0;
  logic [15:0] rdata;
  logic rvalid;
  logic unsupported;
  logic [7:0] cur_f;
  logic [7:0] in_f;
  logic [7:0] ven_f;
  logic [15:0] d;
  logic v;
  logic u;
  int fails = 0;
  int check_count = 0;
  int cycles = 0;
  // rows: write flag, code, write data, expected read
  logic [43:0] rows [16] = '{
    44'h0_DE_0000_0FFF, 44'h0_DF_0000_0000,
    44'h0_19_0000_00B0, 44'h0_4A_0000_07FF, 44'h0_57_0000_0FFF, 44'h0_58_0000_0000,
    44'h0_6B_0000_7FFF, 44'h0_78_0000_0000, 44'h0_79_0000_0000, 44'h0_7B_0000_0000,
    44'h0_7C_0000_0000, 44'h0_80_0000_0000, 44'h1_4A_F123_0123, 44'h1_57_F456_0456,
    44'h1_58_F0AB_00AB, 44'h1_6B_8001_8001};

  always #5 clock = ~clock;
  always #6 link_clock = ~link_clock;

  pws_status pws_status_inst (
    .clock(clock), .nrst(nrst), .link_clock(link_clock), .meas_valid(meas_valid),
    .meas_in(meas_in), .req(req), .bus_error(bus_error), .rdata(rdata), .rvalid(rvalid),
    .unsupported(unsupported), .current_warning_flags(cur_f), .input_warning_flags(in_f),
    .vendor_warning_flags(ven_f));

  pws_host_model pws_host_model_inst (
    .clock(clock), .nrst(nrst), .req(req), .rdata(rdata), .rvalid(rvalid),
    .unsupported(unsupported));

  // ****************************************
  // helpers
  // ****************************************
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e)
    begin
      fails++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic rdchk(input logic [7:0] c, input logic [15:0] e);
    pws_host_model_inst.read_reg(c, d, v, u);
    check({16'h0000, d}, {16'h0000, e});
    check({30'h0, v, u}, 32'h2);
  endtask

  task automatic flags(input logic [31:0] e);
    check({8'h00, cur_f, in_f, ven_f}, e);
  endtask

  task automatic send(input pws_meas_t m);
    @(posedge link_clock);
    meas_valid <= 1'b1;
    meas_in <= m;
    @(posedge link_clock);
    meas_valid <= 1'b0;
    meas_in <= ~m;
    repeat (10) @(posedge clock);
  endtask

  task automatic wr(input logic [7:0] c, input logic [15:0] w);
    pws_host_model_inst.write_reg(c, w);
  endtask

  task automatic clr();
    pws_host_model_inst.clear_faults();
    repeat (2) @(posedge clock);
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 4000)
    begin
      fails++;
      results();
    end
  end

  // ****************************************
  // sequence
  // ****************************************
  initial
  begin
    repeat (10) @(posedge clock);
    nrst <= 1'b1;
    foreach (rows[i])
    begin
      if (rows[i][43:40] == 4'h1)
        wr(rows[i][39:32], rows[i][31:16]);
      rdchk(rows[i][39:32], rows[i][15:0]);
    end
    wr(8'h4A, 16'h0100);
    wr(8'h6B, 16'h1000);
    wr(8'h57, 16'h0800);
    wr(8'h58, 16'h0100);
    wr(8'hDE, 16'h0800);
    wr(8'hDF, 16'h0100);
    send(56'h800_400_0100_1000);
    flags(32'h0);
    send(56'h801_400_0101_1001);
    flags(32'h00204100);
    rdchk(8'h79, 16'h6001);
    rdchk(8'h78, 16'h0001);
    send(56'h400_400_0000_0000);
    flags(32'h00204100);
    clr();
    flags(32'h0);
    rdchk(8'h79, 16'h0000);
    send(56'h0FF_801_0000_0000);
    flags(32'h00002040);
    rdchk(8'h79, 16'h3001);
    clr();
    send(56'h400_0FF_0000_0000);
    flags(32'h00000020);
    clr();
    wr(8'h4A, 16'h0F00);
    wr(8'h6B, 16'hF000);
    send(56'h400_400_0200_7000);
    flags(32'h0);
    send(56'h400_400_FEFF_EFFF);
    flags(32'h00200100);
    clr();
    pws_host_model_inst.read_reg(8'h20, d, v, u);
    check({31'h0, u}, 32'h1);
    check({15'h0000, v, d}, 32'h0001_0000);
    rdchk(8'h78, 16'h0002);
    clr();
    @(posedge clock);
    bus_error <= 1'b1;
    @(posedge clock);
    bus_error <= 1'b0;
    repeat (2) @(posedge clock);
    rdchk(8'h79, 16'h0002);
    nrst <= 1'b0;
    repeat (10) @(posedge clock);
    nrst <= 1'b1;
    rdchk(8'h4A, 16'h07FF);
    rdchk(8'h79, 16'h0000);
    results();
  end
endmodule
